/* File: rtl/uflc_regs.sv */
// Interrupt status, FIFO setup, line format and modem output registers.
// Assumes FIFO counts, source flags and strobes are synchronous to core_clk.
// Function
// - bit 0 low while interrupt pending
// - bits 3:1 give top source
// - bit 4 flags flow character match
// - bit 5 flags flow pin rise
// - bit 7 shows FIFOs enabled
// - bit 6 inverts bit 7 on GPIO
// - other FIFO bits need bit 0 set
// - FIFO reset bits pulse, self clear
// - wake-up enable needs enhanced mode
// - transmit interrupt below trigger or empty
// - receive interrupt while level at or above trigger, with FIFOs off while any data held
// - one table select for both directions
// - fixed trigger tables A, B, C
// - table D from programmable trigger register
// - word length five to eight
// - stop bits one, half, two
// - parity enable bit
// - odd or even parity
// - forced parity mark or space
// - break holds transmit low
// - divisor latch select
// - DTR output inverted bit 0
// - six-bit interrupt code table
`timescale 1ns/10ps
module uflc_regs
    import uflc_pkg::*;
(
    input  wire logic           core_clk,
    input  wire logic           sys_rst,
    input  wire uflc_host_req_s host_req,     // Register access
    output logic [7:0]          host_rdata,   // Read data, registered
    input  wire logic           enh_en,       // Enhanced functions on
    input  wire logic [1:0]     tab_sel,      // Trigger table select
    input  wire logic           trg_wr,       // Programmable trigger write
    input  wire logic           trg_dir,      // 0 receive, 1 transmit
    input  wire logic [7:0]     trg_data,     // Programmable level
    input  wire logic [7:0]     rx_count,     // Receive FIFO level
    input  wire logic [7:0]     tx_count,     // Transmit FIFO level
    input  wire logic           thr_wr,       // Transmit data written
    input  wire logic           lsr_int,      // Line status source
    input  wire logic           rto_int,      // Receive timeout source
    input  wire logic           msr_int,      // Modem status source
    input  wire logic           msr_rd,       // Modem status read
    input  wire logic           flow_match,   // Flow character pulse
    input  wire logic           cts_in,       // Clear-to-send level
    input  wire logic           rts_out,      // Request-to-send level
    input  wire logic           gpio_int,     // GPIO interrupt level
    input  wire logic           tx_ser,       // Serial data from shifter
    output logic                tx_line,      // Serial line output
    output logic                int_pending,  // Any interrupt pending
    output logic                fifo_en,      // FIFOs enabled
    output logic                rx_flush,     // Receive FIFO reset pulse
    output logic                tx_flush,     // Transmit FIFO reset pulse
    output logic                wake_en,      // Wake-up interrupt enable
    output logic [7:0]          rx_trig,      // Receive trigger level
    output logic [7:0]          tx_trig,      // Transmit trigger level
    output uflc_line_fmt_s      line_fmt,     // Decoded format
    output logic                dtr_n         // DTR, active low
);

    // ==========================================================
    // Storage
    logic [7:0] fifo_setup_control;          // FIFO setup
    logic [7:0] line_format_control;          // Line format
    logic [7:0] modem_output_control;          // Modem outputs
    logic [7:0] trg_rx;       // Programmable receive level
    logic [7:0] trg_tx;       // Programmable transmit level
    logic [7:0] tx_prev;      // Last transmit count
    logic       tx_above;     // Filled above trigger since reload
    logic       tx_pend;      // Transmit ready latched
    logic       flow_pend;    // Flow character latched
    logic       pin_pend;     // Flow pin rise latched
    logic       cts_d;        // Previous clear-to-send
    logic       rts_d;        // Previous request-to-send

    // ==========================================================
    // Trigger lookup
    function automatic logic [7:0] pick(input logic [31:0] tab,
                                        input logic [1:0]  idx);
        pick = tab[{idx, 3'h0} +: 8];
    endfunction : pick

    // ==========================================================
    // Address decode
    wire rd_isr = host_req.rd && host_req.addr == ADR_ISR_FCR;
    wire wr_fcr = host_req.wr && host_req.addr == ADR_ISR_FCR;
    wire wr_lcr = host_req.wr && host_req.addr == ADR_LCR;
    wire wr_mcr = host_req.wr && host_req.addr == ADR_MCR;
    wire fcr_go = wr_fcr && host_req.wdata[FCR_EN];

    // ==========================================================
    // Trigger levels, one table select both ways
    wire [1:0] rx_code = fifo_setup_control[7:6];
    wire [1:0] tx_code = fifo_setup_control[5:4];
    always_comb
    begin
        // Table per shared select
        case (tab_sel)
            2'h0:
            begin
                rx_trig = pick(RX_TAB_A, rx_code);
                tx_trig = pick(TX_TAB_A, tx_code);
            end
            2'h1:
            begin
                rx_trig = pick(RX_TAB_B, rx_code);
                tx_trig = pick(TX_TAB_B, tx_code);
            end
            2'h2:
            begin
                rx_trig = pick(RX_TAB_C, rx_code);
                tx_trig = pick(TX_TAB_C, tx_code);
            end
            default:
            begin
                rx_trig = trg_rx;
                tx_trig = trg_tx;
            end
        endcase
    end

    // ==========================================================
    // Interrupt sources
    wire rx_int   = fifo_en ? (rx_count >= rx_trig)
                            : (rx_count != 8'h00);
    wire tx_fall  = tx_count < tx_trig && tx_prev >= tx_trig;
    wire tx_empty = tx_count == 8'h00 && tx_prev != 8'h00
                    && !tx_above;
    wire tx_set   = tx_fall || tx_empty;
    wire pin_set  = enh_en && ((cts_in && !cts_d)
                    || (rts_out && !rts_d));
    wire flow_set = enh_en && flow_match;

    // ==========================================================
    // Priority encode
    logic [5:0] int_code;
    always_comb
    begin
        // Highest level first
        if (lsr_int)
            int_code = IC_LSR;
        else if (rto_int)
            int_code = IC_RTO;
        else if (rx_int)
            int_code = IC_RXR;
        else if (tx_pend)
            int_code = IC_TXR;
        else if (msr_int)
            int_code = IC_MSR;
        else if (flow_pend)
            int_code = IC_FLOW;
        else if (pin_pend)
            int_code = IC_PIN;
        else
            int_code = IC_NONE;
    end

    assign int_pending = !int_code[0];

    // Status byte: bits 5:0 code, 6 GPIO, 7 FIFO mode
    wire [7:0] isr_val = {fifo_en, fifo_en ^ gpio_int, int_code};
    // Reads of status clear a shown transmit or flow source
    wire clr_tx   = (rd_isr && int_code == IC_TXR) || thr_wr;
    wire clr_flow = rd_isr && int_code == IC_FLOW;

    // ==========================================================
    // Outputs
    assign fifo_en = fifo_setup_control[FCR_EN];
    assign wake_en = fifo_setup_control[FCR_WAKE] && enh_en;
    assign dtr_n   = !modem_output_control[MCR_DTR];
    assign tx_line = tx_ser && !line_format_control[6];

    always_comb
    begin
        // Line format decode
        line_fmt.word_bits     = 4'h5 + {2'h0, line_format_control[1:0]};
        line_fmt.stop_half     = line_format_control[2] && line_format_control[1:0] == 2'h0;
        line_fmt.stop_two      = line_format_control[2] && line_format_control[1:0] != 2'h0;
        line_fmt.par_en        = line_format_control[3];
        line_fmt.par_even      = line_format_control[4];
        line_fmt.par_force     = line_format_control[3] && line_format_control[5];
        line_fmt.par_force_val = !line_format_control[4];
        line_fmt.brk           = line_format_control[6];
        line_fmt.dl_sel        = line_format_control[7];
    end

    // ==========================================================
    // FIFO setup register
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            fifo_setup_control      <= FCR_RST;
            rx_flush <= 1'b0;
            tx_flush <= 1'b0;
        end
        else
        begin
            rx_flush <= fcr_go && host_req.wdata[FCR_RXR];
            tx_flush <= fcr_go && host_req.wdata[FCR_TXR];
            if (fcr_go)
            begin
                // Apply fields; reset bits never stored
                fifo_setup_control[FCR_EN]   <= 1'b1;
                fifo_setup_control[FCR_WAKE] <= host_req.wdata[FCR_WAKE];
                fifo_setup_control[7:6]      <= host_req.wdata[7:6];
                if (enh_en)
                    fifo_setup_control[5:4] <= host_req.wdata[5:4];
            end
            else if (wr_fcr)
                fifo_setup_control[FCR_EN] <= 1'b0;
        end
    end

    // ==========================================================
    // Line format and modem registers
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            line_format_control <= LCR_RST;
            modem_output_control <= MCR_RST;
        end
        else
        begin
            if (wr_lcr)
                line_format_control <= host_req.wdata;
            if (wr_mcr)
                modem_output_control <= host_req.wdata;
        end
    end

    // ==========================================================
    // Programmable trigger levels
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            trg_rx <= TRG_RST;
            trg_tx <= TRG_RST;
        end
        else if (trg_wr)
        begin
            if (trg_dir)
                trg_tx <= trg_data;
            else
                trg_rx <= trg_data;
        end
    end

    // ==========================================================
    // Transmit ready tracking
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            tx_prev  <= 8'h00;
            tx_above <= 1'b0;
            tx_pend  <= 1'b0;
        end
        else
        begin
            tx_prev <= tx_count;
            // Reload history, cleared when drained
            if (tx_count > tx_trig)
                tx_above <= 1'b1;
            else if (tx_count == 8'h00)
                tx_above <= 1'b0;
            // Set wins over clear
            if (tx_set)
                tx_pend <= 1'b1;
            else if (clr_tx)
                tx_pend <= 1'b0;
        end
    end

    // ==========================================================
    // Enhanced flags
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            cts_d     <= 1'b0;
            rts_d     <= 1'b0;
            flow_pend <= 1'b0;
            pin_pend  <= 1'b0;
        end
        else
        begin
            cts_d <= cts_in;
            rts_d <= rts_out;
            if (flow_set)
                flow_pend <= 1'b1;
            else if (clr_flow)
                flow_pend <= 1'b0;
            if (pin_set)
                pin_pend <= 1'b1;
            else if (msr_rd)
                pin_pend <= 1'b0;
        end
    end

    // ==========================================================
    // Read data
    always_ff @(posedge core_clk or posedge sys_rst)
    begin
        if (sys_rst)
            host_rdata <= 8'h00;
        else if (rd_isr)
            host_rdata <= isr_val;
        else if (host_req.rd && host_req.addr == ADR_LCR)
            host_rdata <= line_format_control;
        else if (host_req.rd && host_req.addr == ADR_MCR)
            host_rdata <= modem_output_control;
        else if (host_req.rd)
            host_rdata <= 8'h00;
    end

endmodule : uflc_regs

/* File: rtl/uflc_pkg.sv */
// Constants and carriers of the UART register control block.
// Assumes one core clock; the host reaches registers by an address port.
package uflc_pkg;

    // ==========================================================
    // Register offsets
    localparam logic [2:0] ADR_ISR_FCR = 3'h2;  // Status read, FIFO write
    localparam logic [2:0] ADR_LCR     = 3'h3;  // Line format
    localparam logic [2:0] ADR_MCR     = 3'h4;  // Modem outputs

    // ==========================================================
    // Field positions
    localparam int FCR_EN   = 0;
    localparam int FCR_RXR  = 1;
    localparam int FCR_TXR  = 2;
    localparam int FCR_WAKE = 3;
    localparam int MCR_DTR  = 0;

    // Reset values
    localparam logic [7:0] FCR_RST = 8'h00;
    localparam logic [7:0] LCR_RST = 8'h00;
    localparam logic [7:0] MCR_RST = 8'h00;
    localparam logic [7:0] TRG_RST = 8'h01;

    // ==========================================================
    // Six-bit interrupt codes
    localparam logic [5:0] IC_LSR  = 6'h06;
    localparam logic [5:0] IC_RTO  = 6'h0C;
    localparam logic [5:0] IC_RXR  = 6'h04;
    localparam logic [5:0] IC_TXR  = 6'h02;
    localparam logic [5:0] IC_MSR  = 6'h00;
    localparam logic [5:0] IC_FLOW = 6'h10;
    localparam logic [5:0] IC_PIN  = 6'h20;
    localparam logic [5:0] IC_NONE = 6'h01;

    // ==========================================================
    // Trigger tables, entry n in byte n
    localparam logic [31:0] RX_TAB_A = 32'h0E080401;
    localparam logic [31:0] RX_TAB_B = 32'h1C181008;
    localparam logic [31:0] RX_TAB_C = 32'h3C381008;
    localparam logic [31:0] TX_TAB_A = 32'h01010101;
    localparam logic [31:0] TX_TAB_B = 32'h1E180810;
    localparam logic [31:0] TX_TAB_C = 32'h38201008;
    localparam logic [1:0]  TAB_PROG = 2'h3;

    // Host register access
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [2:0] addr;
        logic [7:0] wdata;
    } uflc_host_req_s;

    // Decoded line format
    typedef struct packed {
        logic [3:0] word_bits;
        logic       stop_half;
        logic       stop_two;
        logic       par_en;
        logic       par_even;
        logic       par_force;
        logic       par_force_val;
        logic       brk;
        logic       dl_sel;
    } uflc_line_fmt_s;

endpackage : uflc_pkg

/* File: testbench/uflc_regs_chk.sv */
// Port assertions for the UART register control block.
// Assumes it is bound to uflc_regs from the bench top.
`timescale 1ns/10ps
module uflc_regs_chk
    import uflc_pkg::*;
(
    input wire logic           core_clk,
    input wire logic           sys_rst,
    input wire uflc_host_req_s host_req,
    input wire logic [7:0]     host_rdata,
    input wire logic           enh_en,
    input wire logic           tx_ser,
    input wire logic           tx_line,
    input wire logic           int_pending,
    input wire logic           fifo_en,
    input wire logic           rx_flush,
    input wire logic           tx_flush,
    input wire logic           wake_en,
    input wire uflc_line_fmt_s line_fmt,
    input wire logic           dtr_n
);
    // ==========================================================
    // Write and read decodes
    wire fw = host_req.wr && host_req.addr == ADR_ISR_FCR;  // FIFO setup write
    wire lw = host_req.wr && host_req.addr == ADR_LCR;      // Line format write
    wire mw = host_req.wr && host_req.addr == ADR_MCR;      // Modem write
    wire sr = host_req.rd && host_req.addr == ADR_ISR_FCR;  // Status read

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // ==========================================================
    // Properties
    property p_fifo; fw |=> fifo_en == $past(host_req.wdata[FCR_EN]); endproperty
    a_fifo: assert property (p_fifo) else $error("fifo enable mismatch");
    property p_noflush; fw && !host_req.wdata[0] |=> !rx_flush && !tx_flush; endproperty
    a_noflush: assert property (p_noflush) else $error("flush without enable");
    property p_flush;
        fw && host_req.wdata[0] |=> rx_flush == $past(host_req.wdata[1])
            && tx_flush == $past(host_req.wdata[2]);
    endproperty
    a_flush: assert property (p_flush) else $error("flush pulse missing");
    property p_pulse; rx_flush || tx_flush |-> $past(fw); endproperty
    a_pulse: assert property (p_pulse) else $error("flush pulse too long");
    property p_dtr; mw |=> dtr_n == !$past(host_req.wdata[MCR_DTR]); endproperty
    a_dtr: assert property (p_dtr) else $error("dtr level wrong");
    property p_brk; line_fmt.brk |-> !tx_line; endproperty
    a_brk: assert property (p_brk) else $error("break not held low");
    property p_line; !line_fmt.brk |-> tx_line == tx_ser; endproperty
    a_line: assert property (p_line) else $error("line not following shifter");
    property p_len; lw |=> line_fmt.word_bits == 4'h5 + $past(host_req.wdata[1:0]); endproperty
    a_len: assert property (p_len) else $error("word length wrong");
    property p_stop;
        lw |=> line_fmt.stop_two == ($past(host_req.wdata[2]) && $past(host_req.wdata[1:0]) != 2'h0);
    endproperty
    a_stop: assert property (p_stop) else $error("stop length wrong");
    property p_wake; wake_en |-> enh_en; endproperty
    a_wake: assert property (p_wake) else $error("wake enable without enhanced mode");
    property p_stat;
        sr |=> host_rdata[0] == !$past(int_pending) && host_rdata[7] == $past(fifo_en);
    endproperty
    a_stat: assert property (p_stat) else $error("status bits wrong");

    // Main scenarios reached
    c_flush: cover property (fw && host_req.wdata[1]);
    c_brk: cover property (line_fmt.brk);
    c_int: cover property (sr && int_pending);
endmodule : uflc_regs_chk

/* File: testbench/uflc_peer.sv */
// Remote serial peer: drives its flow pin and watches the line.
// Assumes the bench commands the flow pin through cts_req.
`timescale 1ns/10ps
module uflc_peer
(
    input wire logic core_clk,
    input wire logic cts_req,
    input wire logic tx_line,
    output logic     cts_in = 1'b0,
    output logic     line_lvl = 1'b1
);
    // Flow pin and line sample move one cycle after the command
    always @(posedge core_clk)
    begin
        cts_in   <= cts_req;
        line_lvl <= tx_line;
    end
endmodule : uflc_peer

/* File: testbench/test_uflc_regs.sv */
// Bench: host register calls with expected values.
// Assumes the peer model and the bound checker.
`timescale 1ns/10ps
module test_uflc_regs
    import uflc_pkg::*;
;
    // ==========================================================
    // Signals
    logic core_clk, sys_rst, enh_en, trg_wr, trg_dir, thr_wr, lsr_int, rto_int, msr_int;
    logic msr_rd, flow_match, cts_in, rts_out, gpio_int, tx_ser, tx_line, int_pending;
    logic fifo_en, rx_flush, tx_flush, wake_en, dtr_n, cts_req, line_lvl;
    logic [1:0] tab_sel;
    logic [7:0] trg_data, rx_count, tx_count, host_rdata, rx_trig, tx_trig;
    uflc_host_req_s host_req;
    uflc_line_fmt_s line_fmt;
    int err_count = 0;
    int check_count = 0;
    // Trigger tables A, B, C
    logic [7:0] rxt [3][4] = '{'{8'h01, 8'h04, 8'h08, 8'h0E},
        '{8'h08, 8'h10, 8'h18, 8'h1C}, '{8'h08, 8'h10, 8'h38, 8'h3C}};
    logic [7:0] txt [3][4] = '{'{8'h01, 8'h01, 8'h01, 8'h01},
        '{8'h10, 8'h08, 8'h18, 8'h1E}, '{8'h08, 8'h10, 8'h20, 8'h38}};

    uflc_regs i_uflc_regs (.core_clk, .sys_rst, .host_req, .host_rdata, .enh_en, .tab_sel,
        .trg_wr, .trg_dir, .trg_data, .rx_count, .tx_count, .thr_wr, .lsr_int, .rto_int,
        .msr_int, .msr_rd, .flow_match, .cts_in, .rts_out, .gpio_int, .tx_ser, .tx_line,
        .int_pending, .fifo_en, .rx_flush, .tx_flush, .wake_en, .rx_trig, .tx_trig,
        .line_fmt, .dtr_n);
    uflc_peer i_uflc_peer (.core_clk, .cts_req, .tx_line, .cts_in, .line_lvl);

    // ==========================================================
    // Tasks
    task automatic results;
        if (err_count == 0 && check_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : results
    task automatic cmp(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value at %0t: got %h exp %h", $time, g, e);
        end
    endtask : cmp
    // One write cycle, outputs settled on return
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge core_clk) host_req <= '{rd: 1'b0, wr: 1'b1, addr: a, wdata: d};
        @(posedge core_clk) host_req.wr <= 1'b0;
        #1;
    endtask : wr
    // One read cycle, masked compare
    task automatic rd(input logic [2:0] a, input logic [7:0] e, input logic [7:0] m);
        @(posedge core_clk) host_req <= '{rd: 1'b1, wr: 1'b0, addr: a, wdata: 8'h00};
        @(posedge core_clk) host_req.rd <= 1'b0;
        #1;
        cmp(host_rdata & m, e);
    endtask : rd

    // ==========================================================
    // Clock and watchdog
    initial
    begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    initial
    begin
        #50us;
        err_count++;
        results();
    end

    // ==========================================================
    // Test sequence
    initial
    begin
        sys_rst = 1'b1;
        host_req = '0;
        {enh_en, tab_sel, trg_wr, trg_dir, trg_data, rx_count, tx_count, thr_wr} = '0;
        {lsr_int, rto_int, msr_int, msr_rd, flow_match, rts_out, gpio_int, tx_ser, cts_req} = '0;
        repeat (12) @(posedge core_clk);
        sys_rst <= 1'b0;
        rd(ADR_ISR_FCR, 8'h01, 8'hFF);
        rd(ADR_LCR, 8'h00, 8'hFF);
        cmp(dtr_n, 1'b1);
        // Source priority sweep
        for (int k = 0; k < 4; k++)
        begin
            @(posedge core_clk) {lsr_int, rto_int, msr_int} <= 3'h7 >> k;
            rd(ADR_ISR_FCR, (k == 0) ? 8'h06 : (k == 1) ? 8'h0C : (k == 2) ? 8'h00 : 8'h01,
                8'hFF);
        end
        // FIFO enable, flush pulses and GPIO status
        wr(ADR_ISR_FCR, 8'h07);
        cmp({fifo_en, rx_flush, tx_flush}, 3'h7);
        @(posedge core_clk) #1;
        cmp({rx_flush, tx_flush}, 2'h0);
        rd(ADR_ISR_FCR, 8'hC1, 8'hFF);
        @(posedge core_clk) gpio_int <= 1'b1;
        rd(ADR_ISR_FCR, 8'h80, 8'hC0);
        wr(ADR_ISR_FCR, 8'hC6);
        cmp({fifo_en, rx_flush, tx_flush}, 3'h0);
        rd(ADR_ISR_FCR, 8'h40, 8'hC0);
        @(posedge core_clk) {gpio_int, enh_en} <= 2'h1;
        // Fixed trigger tables
        for (int t = 0; t < 3; t++)
            for (int i = 0; i < 4; i++)
            begin
                @(posedge core_clk) tab_sel <= 2'(t);
                wr(ADR_ISR_FCR, {2'(i), 2'(i), 4'h1});
                cmp(rx_trig, rxt[t][i]);
                cmp(tx_trig, txt[t][i]);
            end
        // Programmable trigger levels
        @(posedge core_clk) {tab_sel, trg_wr, trg_dir, trg_data} <= {2'h3, 2'h2, 8'h21};
        @(posedge core_clk) {trg_dir, trg_data} <= {1'b1, 8'h13};
        @(posedge core_clk) {tab_sel, trg_wr} <= 3'h6;
        #1;
        cmp(rx_trig, 8'h21);
        cmp(tx_trig, 8'h13);
        // Wake enable gated by enhanced mode
        @(posedge core_clk) tab_sel <= 2'h0;
        wr(ADR_ISR_FCR, 8'h09);
        cmp(wake_en, 1'b1);
        @(posedge core_clk) enh_en <= 1'b0;
        #1 cmp(wake_en, 1'b0);
        @(posedge core_clk) enh_en <= 1'b1;
        // Transmit ready, cleared by status read or data write
        for (int k = 0; k < 2; k++)
        begin
            @(posedge core_clk) tx_count <= 8'h02;
            @(posedge core_clk) tx_count <= 8'h00;
            @(posedge core_clk) thr_wr <= 1'(k);
            @(posedge core_clk) thr_wr <= 1'b0;
            rd(ADR_ISR_FCR, k ? 8'hC1 : 8'hC2, 8'hFF);
            rd(ADR_ISR_FCR, 8'hC1, 8'hFF);
        end
        // Receive trigger crossing
        @(posedge core_clk) rx_count <= 8'h01;
        @(posedge core_clk);
        rd(ADR_ISR_FCR, 8'hC4, 8'hFF);
        @(posedge core_clk) rx_count <= 8'h00;
        @(posedge core_clk);
        rd(ADR_ISR_FCR, 8'hC1, 8'hFF);
        // Flow character and flow pin flags
        @(posedge core_clk) flow_match <= 1'b1;
        @(posedge core_clk) flow_match <= 1'b0;
        rd(ADR_ISR_FCR, 8'hD0, 8'hFF);
        rd(ADR_ISR_FCR, 8'hC1, 8'hFF);
        @(posedge core_clk) cts_req <= 1'b1;
        repeat (2) @(posedge core_clk);
        rd(ADR_ISR_FCR, 8'hE0, 8'hFF);
        @(posedge core_clk) msr_rd <= 1'b1;
        @(posedge core_clk) msr_rd <= 1'b0;
        rd(ADR_ISR_FCR, 8'hC1, 8'hFF);
        // Line format fields
        for (int i = 0; i < 4; i++)
        begin
            wr(ADR_LCR, 8'h0C | 8'(i));
            cmp(line_fmt.word_bits, 8'(5 + i));
            cmp({line_fmt.stop_half, line_fmt.stop_two}, {i == 0, i != 0});
            wr(ADR_LCR, 8'h08 | 8'(i << 4));
            cmp({line_fmt.par_en, line_fmt.par_force}, {1'b1, i[1]});
            cmp(i[1] ? line_fmt.par_force_val : line_fmt.par_even, i[1] ? !i[0] : i[0]);
        end
        rd(ADR_LCR, 8'h38, 8'hFF);
        // Break and divisor select
        @(posedge core_clk) tx_ser <= 1'b1;
        wr(ADR_LCR, 8'h40);
        @(posedge core_clk) #1;
        cmp({tx_line, line_lvl}, 2'h0);
        wr(ADR_LCR, 8'h80);
        @(posedge core_clk) #1;
        cmp({tx_line, line_lvl, line_fmt.dl_sel}, 3'h7);
        // Modem output and unmapped place
        wr(ADR_MCR, 8'h01);
        cmp(dtr_n, 1'b0);
        rd(ADR_MCR, 8'h01, 8'hFF);
        wr(3'h7, 8'hFF);
        rd(3'h7, 8'h00, 8'hFF);
        results();
    end
endmodule : test_uflc_regs

bind uflc_regs uflc_regs_chk i_uflc_regs_chk (.core_clk, .sys_rst, .host_req, .host_rdata,
    .enh_en, .tx_ser, .tx_line, .int_pending, .fifo_en, .rx_flush, .tx_flush, .wake_en,
    .line_fmt, .dtr_n);
